// >>> hdl/gate_ctrl_pkg.sv
// constants shared by the isolator gate driver enable control
package gate_ctrl_pkg;

	// ------------------------------------------------------------
	// clock and charge pump timing
	// ------------------------------------------------------------
	localparam int CLK_HZ  = 100_000_000; // system clock rate
	localparam int PUMP_HZ = 62_500;      // pump switching rate
	localparam int PUMP_HALF_W = 10;
	// half period in cycles; the pump clock toggles once per half
	localparam logic [PUMP_HALF_W-1:0] PUMP_HALF_CNT =
		PUMP_HALF_W'(CLK_HZ / (2 * PUMP_HZ));

	// ------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------
	localparam int NUM_DRV    = 5;
	localparam int DRV_PHASEA = 0;
	localparam int DRV_PHASEB = 1;
	localparam int DRV_PHASEC = 2;
	localparam int DRV_BRIDGE = 3;
	localparam int DRV_REVERSE = 4;

	// ------------------------------------------------------------
	// serial frame layout
	// ------------------------------------------------------------
	localparam int FRAME_BITS = 32;
	localparam int BITCNT_W   = 6;
	localparam logic [BITCNT_W-1:0] FRAME_BITS_CNT = 6'h20;
	localparam int ON_LSB     = 0;  // on commands, one bit per driver
	localparam int OFF_LSB    = 8;  // off commands, one bit per driver

	// ------------------------------------------------------------
	// register port
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_CONFIG  = 4'h0;
	localparam logic [ADDR_W-1:0] REG_OCLEVEL = 4'h1;
	localparam logic [ADDR_W-1:0] REG_PULSE   = 4'h2;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 4'h3;
	localparam logic [ADDR_W-1:0] REG_COMMAND = 4'h4;

	localparam int CFG_PUMP_BIT  = 0;
	localparam int CFG_TOPO_BIT  = 1;
	localparam int CFG_GATED_BIT = 2;
	localparam logic [2:0] CFG_RST = 3'h1;  // pump on, common source

	localparam logic [7:0] OCLEVEL_RST = 8'h00;
	localparam logic [7:0] PULSE_RST   = 8'h10;

	localparam int STAT_PEND_BIT = 5;
	localparam int STAT_PUMP_BIT = 6;

	typedef enum logic [0:0] {RX_IDLE, RX_SHIFT} rx_state_type;

endpackage : gate_ctrl_pkg

// >>> hdl/serial_frame_rx.sv
// serial command frame receiver: 32 bits msb first, checked at select release
`timescale 1ns/1ps
module serial_frame_rx (
	input  wire logic                                 clock,
	input  wire logic                                 nrst,
	input  wire logic                                 sck,
	input  wire logic                                 mosi,
	input  wire logic                                 cs_n,
	output logic                                      frame_valid,
	output logic [gate_ctrl_pkg::FRAME_BITS-1:0]      frame_word
);

	gate_ctrl_pkg::rx_state_type               state_r, state_nxt;
	logic                                      sck_r;
	logic [gate_ctrl_pkg::BITCNT_W-1:0]        cnt_r, cnt_nxt;
	logic [gate_ctrl_pkg::FRAME_BITS-1:0]      shift_r, shift_nxt;
	logic                                      valid_r, valid_nxt;
	logic [gate_ctrl_pkg::FRAME_BITS-1:0]      word_r, word_nxt;

	// ------------------------------------------------------------
	// frame assembly
	// ------------------------------------------------------------
	// count saturates one past a full frame so long frames are refused
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		shift_nxt = shift_r;
		valid_nxt = 1'b0;
		word_nxt  = word_r;
		case (state_r)
			gate_ctrl_pkg::RX_IDLE: begin
				if (!cs_n) begin
					state_nxt = gate_ctrl_pkg::RX_SHIFT;
					cnt_nxt   = '0;
				end
			end
			gate_ctrl_pkg::RX_SHIFT: begin
				if (cs_n) begin
					state_nxt = gate_ctrl_pkg::RX_IDLE;
					if (cnt_r == gate_ctrl_pkg::FRAME_BITS_CNT) begin
						valid_nxt = 1'b1;
						word_nxt  = shift_r;
					end
				end else if (sck && !sck_r) begin
					shift_nxt = {shift_r[gate_ctrl_pkg::FRAME_BITS-2:0], mosi};
					if (cnt_r <= gate_ctrl_pkg::FRAME_BITS_CNT)
						cnt_nxt = cnt_r + 1'b1;
				end
			end
			default: state_nxt = gate_ctrl_pkg::RX_IDLE;
		endcase
	end

	// state registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r <= gate_ctrl_pkg::RX_IDLE;
			sck_r   <= 1'b1;
			cnt_r   <= '0;
			shift_r <= '0;
			valid_r <= 1'b0;
			word_r  <= '0;
		end else begin
			state_r <= state_nxt;
			sck_r   <= sck;
			cnt_r   <= cnt_nxt;
			shift_r <= shift_nxt;
			valid_r <= valid_nxt;
			word_r  <= word_nxt;
		end
	end

	assign frame_valid = valid_r;
	assign frame_word  = word_r;

endmodule : serial_frame_rx

// >>> hdl/gate_enable_ctrl.sv
// enable latches, charge pump gating and register port for five gate drivers
//
// How it works
// - each of the five drivers has its own latched enable, uncoupled
// - reset clears every latched enable and command bit; all gates off
// - on bit 1 with off bit 0 sets the latch and raises the gate
// - on bit 0 with off bit 1 clears the latch and lowers the gate
// - equal on and off bits leave that driver's latch unchanged
// - command bits clear after use and always read back as zero
// - every driver's command pair is judged on its own in one frame
// - a commanded off acts at once, save the gated reverse case
// - gated reverse off waits until sensed current exceeds the set level
// - latched enables are readable as status bits
// - internal protection inputs may also clear the latched enables
// - clearing the pump enable bit stops the charge pump
// - sleep mode keeps the charge pump stopped regardless of enable
// - pump switches at 62.5 kHz derived from the system clock
// - a rising latch gives a pulse current phase, then hold current
// - common-drain setting inverts the reverse gate against its latch
// - topology bit 1 picks common drain; reset 0 is common source
// - a command is a 32-bit word, msb first on the data input
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module gate_enable_ctrl (
	input  wire logic                                clock,
	input  wire logic                                nrst,
	input  wire logic                                sck,
	input  wire logic                                mosi,
	input  wire logic                                cs_n,
	input  wire logic [gate_ctrl_pkg::ADDR_W-1:0]    addr,
	input  wire logic [31:0]                         wdata,
	input  wire logic                                wr,
	input  wire logic                                rd,
	output logic [31:0]                              rdata,
	input  wire logic [7:0]                          sensed_current_monitor,
	input  wire logic [gate_ctrl_pkg::NUM_DRV-1:0]   protect_off,
	input  wire logic                                sleep_mode,
	output logic                                     phase_a_gate_out,
	output logic                                     phase_b_gate_out,
	output logic                                     phase_c_gate_out,
	output logic                                     bridge_gate_out,
	output logic                                     reverse_gate_out,
	output logic [gate_ctrl_pkg::NUM_DRV-1:0]        pulse_phase,
	output logic [gate_ctrl_pkg::NUM_DRV-1:0]        hold_phase,
	output logic                                     pump_clk
);

	localparam int N   = gate_ctrl_pkg::NUM_DRV;
	localparam int REV = gate_ctrl_pkg::DRV_REVERSE;

	// next state of one driver's latch from its command pair
	function automatic logic apply_pair(input logic on_bit,
		input logic off_bit, input logic cur);
		if (on_bit && !off_bit)
			return 1'b1;
		else if (off_bit && !on_bit)
			return 1'b0;
		else
			return cur;
	endfunction : apply_pair

	// ------------------------------------------------------------
	// serial command frames
	// ------------------------------------------------------------
	logic        frame_valid;
	logic [31:0] frame_word;
	logic [N-1:0] driver_on_command;
	logic [N-1:0] driver_off_command;

	serial_frame_rx rx (
		.clock       (clock),
		.nrst        (nrst),
		.sck         (sck),
		.mosi        (mosi),
		.cs_n        (cs_n),
		.frame_valid (frame_valid),
		.frame_word  (frame_word)
	);

	// command bits live only in the frame cycle, so nothing stays set
	assign driver_on_command  = frame_valid ?
		frame_word[gate_ctrl_pkg::ON_LSB +: N] : '0;
	assign driver_off_command = frame_valid ?
		frame_word[gate_ctrl_pkg::OFF_LSB +: N] : '0;

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	logic [2:0]  cfg_r, cfg_nxt;
	logic [7:0]  oclevel_r, oclevel_nxt;
	logic [7:0]  pulse_len_r, pulse_len_nxt;
	logic        pump_enable_bit;
	logic        supply_topology_select;
	logic        current_gated_reverse_off;

	assign pump_enable_bit           = cfg_r[gate_ctrl_pkg::CFG_PUMP_BIT];
	assign supply_topology_select    = cfg_r[gate_ctrl_pkg::CFG_TOPO_BIT];
	assign current_gated_reverse_off = cfg_r[gate_ctrl_pkg::CFG_GATED_BIT];

	// writes to the config, level and pulse offsets; others are dropped
	always_comb begin
		cfg_nxt       = cfg_r;
		oclevel_nxt   = oclevel_r;
		pulse_len_nxt = pulse_len_r;
		if (wr) begin
			case (addr)
				gate_ctrl_pkg::REG_CONFIG:  cfg_nxt       = wdata[2:0];
				gate_ctrl_pkg::REG_OCLEVEL: oclevel_nxt   = wdata[7:0];
				gate_ctrl_pkg::REG_PULSE:   pulse_len_nxt = wdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cfg_r       <= gate_ctrl_pkg::CFG_RST;
			oclevel_r   <= gate_ctrl_pkg::OCLEVEL_RST;
			pulse_len_r <= gate_ctrl_pkg::PULSE_RST;
		end else begin
			cfg_r       <= cfg_nxt;
			oclevel_r   <= oclevel_nxt;
			pulse_len_r <= pulse_len_nxt;
		end
	end

	// ------------------------------------------------------------
	// latched enables
	// ------------------------------------------------------------
	logic [N-1:0] driver_latched_enable, latch_nxt;
	logic         rev_pending_r, rev_pending_nxt;
	logic         above_level;

	assign above_level = sensed_current_monitor > oclevel_r;

	// release of a held reverse off is judged first so that a fresh
	// frame in the same cycle still has the last word
	always_comb begin
		latch_nxt       = driver_latched_enable;
		rev_pending_nxt = rev_pending_r;
		if (rev_pending_r && (above_level || !current_gated_reverse_off)) begin
			latch_nxt[REV]  = 1'b0;
			rev_pending_nxt = 1'b0;
		end
		for (int i = 0; i < N; i++) begin
			latch_nxt[i] = apply_pair(driver_on_command[i],
				driver_off_command[i], latch_nxt[i]);
		end
		if (driver_on_command[REV] && !driver_off_command[REV])
			rev_pending_nxt = 1'b0;
		// gated mode: hold the reverse driver on until current exceeds the set level
		if (driver_off_command[REV] && !driver_on_command[REV] &&
			current_gated_reverse_off && driver_latched_enable[REV] &&
			!above_level) begin
			latch_nxt[REV]  = 1'b1;
			rev_pending_nxt = 1'b1;
		end
		latch_nxt = latch_nxt & ~protect_off;
		if (protect_off[REV])
			rev_pending_nxt = 1'b0;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			driver_latched_enable <= '0;
			rev_pending_r         <= 1'b0;
		end else begin
			driver_latched_enable <= latch_nxt;
			rev_pending_r         <= rev_pending_nxt;
		end
	end

	// gates follow the latches; reverse flips in common drain
	assign phase_a_gate_out = driver_latched_enable[gate_ctrl_pkg::DRV_PHASEA];
	assign phase_b_gate_out = driver_latched_enable[gate_ctrl_pkg::DRV_PHASEB];
	assign phase_c_gate_out = driver_latched_enable[gate_ctrl_pkg::DRV_PHASEC];
	assign bridge_gate_out  = driver_latched_enable[gate_ctrl_pkg::DRV_BRIDGE];
	assign reverse_gate_out = driver_latched_enable[REV] ^
		supply_topology_select;

	// ------------------------------------------------------------
	// pulse and hold current phases
	// ------------------------------------------------------------
	logic [7:0] pulse_cnt_r [N];
	logic [7:0] pulse_cnt_nxt [N];

	// the length is sampled at the rising edge; later writes apply next time
	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (latch_nxt[i] && !driver_latched_enable[i])
				pulse_cnt_nxt[i] = pulse_len_r;
			else if (!driver_latched_enable[i])
				pulse_cnt_nxt[i] = '0;
			else if (pulse_cnt_r[i] != '0)
				pulse_cnt_nxt[i] = pulse_cnt_r[i] - 8'h01;
			else
				pulse_cnt_nxt[i] = '0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < N; i++)
				pulse_cnt_r[i] <= '0;
		end else begin
			for (int i = 0; i < N; i++)
				pulse_cnt_r[i] <= pulse_cnt_nxt[i];
		end
	end

	always_comb begin
		for (int i = 0; i < N; i++) begin
			pulse_phase[i] = driver_latched_enable[i] &&
				(pulse_cnt_r[i] != '0);
			hold_phase[i]  = driver_latched_enable[i] &&
				(pulse_cnt_r[i] == '0);
		end
	end

	// ------------------------------------------------------------
	// charge pump clock
	// ------------------------------------------------------------
	logic                                  pump_active;
	logic [gate_ctrl_pkg::PUMP_HALF_W-1:0] pump_div_r, pump_div_nxt;
	logic                                  pump_clk_r, pump_clk_nxt;

	assign pump_active = pump_enable_bit && !sleep_mode;

	// stopped pump parks low and restarts a full half period later
	always_comb begin
		pump_div_nxt = '0;
		pump_clk_nxt = 1'b0;
		if (pump_active) begin
			pump_clk_nxt = pump_clk_r;
			if (pump_div_r == gate_ctrl_pkg::PUMP_HALF_CNT - 1'b1) begin
				pump_clk_nxt = !pump_clk_r;
			end else begin
				pump_div_nxt = pump_div_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pump_div_r <= '0;
			pump_clk_r <= 1'b0;
		end else begin
			pump_div_r <= pump_div_nxt;
			pump_clk_r <= pump_clk_nxt;
		end
	end

	assign pump_clk = pump_clk_r;

	// ------------------------------------------------------------
	// register reads, data one cycle after the strobe
	// ------------------------------------------------------------
	logic [31:0] rdata_r, rdata_nxt;

	always_comb begin
		rdata_nxt = '0;
		if (rd) begin
			case (addr)
				gate_ctrl_pkg::REG_CONFIG:  rdata_nxt[2:0] = cfg_r;
				gate_ctrl_pkg::REG_OCLEVEL: rdata_nxt[7:0] = oclevel_r;
				gate_ctrl_pkg::REG_PULSE:   rdata_nxt[7:0] = pulse_len_r;
				gate_ctrl_pkg::REG_STATUS: begin
					rdata_nxt[N-1:0] = driver_latched_enable;
					rdata_nxt[gate_ctrl_pkg::STAT_PEND_BIT] = rev_pending_r;
					rdata_nxt[gate_ctrl_pkg::STAT_PUMP_BIT] = pump_active;
				end
				gate_ctrl_pkg::REG_COMMAND: rdata_nxt = '0;
				default: rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			rdata_r <= '0;
		else
			rdata_r <= rdata_nxt;
	end

	assign rdata = rdata_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence on_frame_a;
		frame_valid && driver_on_command[0] && !driver_off_command[0] &&
			!protect_off[0];
	endsequence

	sequence pulse_then_hold_a;
		pulse_phase[0] ##1 (pulse_phase[0] || hold_phase[0]);
	endsequence

	chk_on_sets_latch: assert property (
		on_frame_a |=> phase_a_gate_out && driver_latched_enable[0])
		else $error("on command did not raise phase a gate");

	chk_off_clears_latch: assert property (
		frame_valid && driver_off_command[1] && !driver_on_command[1]
		|=> !phase_b_gate_out)
		else $error("off command did not drop phase b gate");

	chk_equal_keeps: assert property (
		frame_valid && (driver_on_command[2] == driver_off_command[2]) &&
		!protect_off[2] |=> $stable(driver_latched_enable[2]))
		else $error("equal command bits changed phase c latch");

	chk_pending_holds: assert property (
		rev_pending_r && current_gated_reverse_off && !above_level &&
		!protect_off[REV] |=> driver_latched_enable[REV])
		else $error("reverse turned off before current threshold");

	chk_pending_release: assert property (
		rev_pending_r && above_level && !frame_valid && !protect_off[REV]
		|=> !driver_latched_enable[REV] && !rev_pending_r)
		else $error("reverse off not applied above threshold");

	chk_protect_off: assert property (
		protect_off[3] |=> !bridge_gate_out)
		else $error("protection did not clear bridge latch");

	chk_drain_invert: assert property (
		supply_topology_select && !driver_latched_enable[REV]
		|-> reverse_gate_out)
		else $error("reverse gate not inverted in common drain");

	chk_pump_sleep: assert property (
		sleep_mode |=> !pump_clk && pump_div_r == '0)
		else $error("pump running during sleep");

	chk_pump_off_bit: assert property (
		!pump_enable_bit ##1 !pump_enable_bit |-> !pump_clk)
		else $error("pump running with enable bit clear");

	chk_pump_toggle: assert property (
		pump_active && pump_div_r == gate_ctrl_pkg::PUMP_HALF_CNT - 1'b1
		|=> pump_clk != $past(pump_clk))
		else $error("pump clock missed its half period toggle");

	chk_pulse_phase: assert property (
		$rose(driver_latched_enable[0]) && pulse_len_r > 8'h01 &&
		!protect_off[0] |-> pulse_then_hold_a)
		else $error("pulse current phase missing after turn on");

	chk_status_read: assert property (
		rd && addr == gate_ctrl_pkg::REG_STATUS
		|=> rdata[N-1:0] == $past(driver_latched_enable))
		else $error("status read does not show latched enables");

endmodule : gate_enable_ctrl

// >>> sim/host_serial_model.sv
// host side serial controller model that clocks command frames in
`timescale 1ns/1ps
module host_serial_model (
	input  wire logic clock,
	output logic      sck,
	output logic      mosi,
	output logic      cs_n
);
	// --------------------
	// idle levels
	// --------------------
	// clock stands low between frames, data falls to its pull-down level
	initial begin
		sck  = 1'b0;
		mosi = 1'b0;
		cs_n = 1'b1;
	end

	// --------------------
	// frame sender
	// --------------------
	// msb first; a short count sends only the top bits, to be refused
	task automatic send_frame(input logic [31:0] word, input int nbits);
		@(posedge clock);
		cs_n <= 1'b0;
		for (int i = 0; i < nbits; i++) begin
			mosi <= word[31-i];
			repeat (2) @(posedge clock);
			sck <= 1'b1;
			repeat (2) @(posedge clock);
			sck <= 1'b0;
		end
		@(posedge clock);
		mosi <= 1'b0;
		cs_n <= 1'b1;
		@(posedge clock);
	endtask : send_frame
endmodule : host_serial_model

// >>> sim/gate_enable_ctrl_tb_top.sv
// self-checking bench for the gate driver enable control
`timescale 1ns/1ps
module gate_enable_ctrl_tb_top;
	logic                             clock;
	logic                             nrst;
	logic                             sck;
	logic                             mosi;
	logic                             cs_n;
	logic [gate_ctrl_pkg::ADDR_W-1:0] addr;
	logic [31:0]                      wdata;
	logic                             wr;
	logic                             rd;
	logic [31:0]                      rdata;
	logic [7:0]                       cur;
	logic [4:0]                       prot;
	logic                             sleep;
	logic [4:0]                       gates;
	logic [4:0]                       pulse_phase;
	logic [4:0]                       hold_phase;
	logic                             pump_clk;
	logic [4:0]                       exp_latch;
	logic                             topo;
	logic [31:0]                      word;
	logic [31:0]                      got;
	int                               fails;
	int                               comparisons;
	int                               seed;
	int                               n;
	int                               hi;

	host_serial_model i_host_serial_model (.clock(clock), .sck(sck),
		.mosi(mosi), .cs_n(cs_n));

	gate_enable_ctrl i_gate_enable_ctrl (.clock(clock), .nrst(nrst),
		.sck(sck), .mosi(mosi), .cs_n(cs_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .sensed_current_monitor(cur),
		.protect_off(prot), .sleep_mode(sleep),
		.phase_a_gate_out(gates[0]), .phase_b_gate_out(gates[1]),
		.phase_c_gate_out(gates[2]), .bridge_gate_out(gates[3]),
		.reverse_gate_out(gates[4]), .pulse_phase(pulse_phase),
		.hold_phase(hold_phase), .pump_clk(pump_clk));

	// --------------------
	// helpers
	// --------------------
	// expected latches: each driver judged on its own pair of bits
	function automatic logic [4:0] next_latch(input logic [4:0] l,
		input logic [31:0] w);
		logic [4:0] x;
		x = l;
		for (int i = 0; i < 5; i++) begin
			if (w[gate_ctrl_pkg::ON_LSB+i] && !w[gate_ctrl_pkg::OFF_LSB+i])
				x[i] = 1'b1;
			if (!w[gate_ctrl_pkg::ON_LSB+i] && w[gate_ctrl_pkg::OFF_LSB+i])
				x[i] = 1'b0;
		end
		return x;
	endfunction : next_latch

	task automatic check_val(input string what, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask : check_val

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clock);
		wr    <= 1'b0;
	endtask : reg_write

	// read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clock);
		rd   <= 1'b0;
		@(negedge clock);
		d = rdata;
	endtask : reg_read

	task automatic check_state();
		@(negedge clock);
		check_val("gates", {27'h0, exp_latch ^ {topo, 4'h0}}, {27'h0, gates});
		reg_read(gate_ctrl_pkg::REG_STATUS, got);
		check_val("status", {27'h0, exp_latch}, {27'h0, got[4:0]});
	endtask : check_state

	// frame plus settling time until the latches have moved
	task automatic frame(input logic [31:0] w);
		i_host_serial_model.send_frame(w, 32);
		repeat (3) @(posedge clock);
	endtask : frame

	// counts pump clock high cycles over a fixed window
	task automatic pump_count(output int c);
		c = 0;
		for (int k = 0; k < 1700; k++) begin
			@(negedge clock);
			if (pump_clk !== 1'b0) c++;
		end
	endtask : pump_count

	task automatic complete_run();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : complete_run

	// --------------------
	// clock and sequence
	// --------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	initial begin
		seed = 75374;
		nrst = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		cur = 8'h00;
		prot = 5'h00;
		sleep = 1'b0;
		exp_latch = 5'h00;
		topo = 1'b0;
		fails = 0;
		comparisons = 0;
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		check_state();
		reg_read(gate_ctrl_pkg::REG_CONFIG, got);
		check_val("config", 32'h1, got);
		reg_read(gate_ctrl_pkg::REG_PULSE, got);
		check_val("pulse len", 32'h10, got);
		reg_read(4'hF, got);
		check_val("unmapped", 32'h0, got);
		$display("test reset done");
		// corners first, then random words; topology flips midway
		for (n = 0; n < 24; n++) begin
			word = $random(seed);
			if (n == 0) word = 32'h0000001F;
			if (n == 1) word = 32'h00001F1F;
			if (n == 2) word = 32'h00000000;
			if (n == 12) begin
				topo = 1'b1;
				reg_write(gate_ctrl_pkg::REG_CONFIG, 32'h3);
			end
			frame(word);
			exp_latch = next_latch(exp_latch, word);
			check_state();
			reg_read(gate_ctrl_pkg::REG_COMMAND, got);
			check_val("command", 32'h0, got);
		end
		// a frame one bit short would flip every latch if taken
		word = {19'h0, exp_latch, 3'h0, ~exp_latch};
		i_host_serial_model.send_frame(word, 31);
		repeat (3) @(posedge clock);
		check_state();
		$display("test frames done");
		// gated reverse off waits for current strictly above the level
		topo = 1'b0;
		reg_write(gate_ctrl_pkg::REG_CONFIG, 32'h5);
		reg_write(gate_ctrl_pkg::REG_OCLEVEL, 32'h40);
		cur <= 8'h40;
		frame(32'h00000010);
		exp_latch[4] = 1'b1;
		frame(32'h00001000);
		repeat (10) @(posedge clock);
		check_state();
		check_val("pending", 32'h1, {31'h0, got[5]});
		@(posedge clock);
		cur <= 8'h41;
		for (hi = 0; hi < 20 && gates[4] !== 1'b0; hi++) @(negedge clock);
		if (hi == 20) begin
			fails++;
			complete_run();
		end
		exp_latch[4] = 1'b0;
		check_state();
		// protection clears a latch that stays cleared afterwards
		frame(32'h00000002);
		exp_latch[1] = 1'b1;
		check_state();
		@(posedge clock);
		prot <= 5'h02;
		repeat (3) @(posedge clock);
		prot <= 5'h00;
		exp_latch[1] = 1'b0;
		check_state();
		$display("test gated and protect done");
		// pulse phase lasts the programmed count, then hold
		word = ($random(seed) & 32'hF) + 32'h2;
		reg_write(gate_ctrl_pkg::REG_PULSE, word);
		frame(32'h00000100);
		i_host_serial_model.send_frame(32'h00000001, 32);
		hi = 0;
		for (n = 0; n < 60; n++) begin
			@(negedge clock);
			if (pulse_phase[0] === 1'b1) hi++;
		end
		check_val("pulse cycles", word, 32'(hi));
		check_val("hold", 32'h1, {31'h0, hold_phase[0]});
		$display("test pulse done");
		// pump half period, then sleep and disable keep it still
		// start from a low half so the whole high half is counted
		for (n = 0; n < 2000 && pump_clk !== 1'b0; n++) @(negedge clock);
		for (hi = 0; hi < 2000 && pump_clk !== 1'b1; hi++) @(negedge clock);
		if (n == 2000 || hi == 2000) begin
			fails++;
			complete_run();
		end
		hi = 0;
		for (n = 0; n < 2000 && pump_clk === 1'b1; n++) begin
			@(negedge clock);
			hi++;
		end
		check_val("pump half", 32'(100_000_000 / (2 * 62_500)), 32'(hi));
		@(posedge clock);
		sleep <= 1'b1;
		repeat (4) @(posedge clock);
		pump_count(hi);
		check_val("pump sleep", 32'h0, 32'(hi));
		@(posedge clock);
		sleep <= 1'b0;
		reg_write(gate_ctrl_pkg::REG_CONFIG, 32'h0);
		repeat (4) @(posedge clock);
		pump_count(hi);
		check_val("pump off", 32'h0, 32'(hi));
		$display("test pump done");
		complete_run();
	end
endmodule : gate_enable_ctrl_tb_top
